// ==== src/aofsc_pkg.sv ====
package aofsc_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned HOLD0_MS = 0;
	localparam int unsigned HOLD1_MS = 512;
	localparam int unsigned HOLD2_MS = 1024;
	localparam int unsigned HOLD3_MS = 2048;
	localparam int unsigned ST_SETTLE_MS = 50;

	// Register indices; byte address is four times the index
	localparam int unsigned ADR_IDX_MSB = 7;
	localparam int unsigned ADR_IDX_LSB = 2;
	localparam logic [5:0] IDX_ORIENT = 6'h2D;
	localparam logic [5:0] IDX_FLAT_ANGLE = 6'h2E;
	localparam logic [5:0] IDX_FLAT_HOLD = 6'h2F;
	localparam logic [5:0] IDX_WM = 6'h30;
	localparam logic [5:0] IDX_ST = 6'h32;
	localparam logic [5:0] IDX_STATUS = 6'h3F;

	// Reset values and writable-bit masks
	localparam logic [7:0] RST_ORIENT = 8'h48;
	localparam logic [7:0] RST_FLAT_ANGLE = 8'h08;
	localparam logic [7:0] RST_FLAT_HOLD = 8'h11;
	localparam logic [7:0] RST_WM = 8'h00;
	localparam logic [7:0] RST_ST = 8'h00;
	localparam logic [7:0] MASK_ORIENT = 8'h7F;
	localparam logic [7:0] MASK_FLAT_ANGLE = 8'h3F;
	localparam logic [7:0] MASK_FLAT_HOLD = 8'h37;
	localparam logic [7:0] MASK_WM = 8'h3F;
	localparam logic [7:0] MASK_ST = 8'h17;

	// Field positions
	localparam int unsigned UD_EN_BIT = 6;
	localparam int unsigned THETA_MSB = 5;
	localparam int unsigned HOLD_MSB = 5;
	localparam int unsigned HOLD_LSB = 4;
	localparam int unsigned HY_MSB = 2;
	localparam int unsigned ST_AMP_BIT = 4;
	localparam int unsigned ST_SIGN_BIT = 2;
	localparam int unsigned ST_AXIS_MSB = 1;
	localparam logic [1:0] ST_AXIS_OFF = 2'h0;
	localparam int unsigned STAT_FLAT_BIT = 0;
	localparam int unsigned STAT_UD_BIT = 1;
	localparam int unsigned STAT_SETTLED_BIT = 2;

	function automatic logic [11:0] hold_ms(input logic [1:0] sel);
		logic [11:0] ms;
		unique case (sel)
			2'h0: ms = 12'(HOLD0_MS);
			2'h1: ms = 12'(HOLD1_MS);
			2'h2: ms = 12'(HOLD2_MS);
			2'h3: ms = 12'(HOLD3_MS);
		endcase
		return ms;
	endfunction : hold_ms

	// Angle at or above which a flat state is left
	function automatic logic [7:0] flat_leave_bound(input logic [5:0] theta, input logic [2:0] hy);
		return {2'h0, theta} + {4'h0, hy, 1'b0} + {7'h00, (hy != 3'h0)};
	endfunction : flat_leave_bound

endpackage : aofsc_pkg

// ==== src/aofsc_ms_timer.sv ====
`timescale 1ns/1ps
module aofsc_ms_timer #(
	parameter int unsigned TICK_CYCLES = aofsc_pkg::TICK_CYCLES
) (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Synchronous reset, high
	input wire logic restart_i, // Start or restart the wait
	input wire logic [11:0] target_ms_i, // Wait length in ms
	output logic fire_o // One-cycle pulse at expiry
);
	import aofsc_pkg::*;

	typedef enum logic {AOFSC_TM_IDLE, AOFSC_TM_WAIT} aofsc_tm_state_t;

	aofsc_tm_state_t state_reg, state_next;
	logic [15:0] cyc_reg, cyc_next;
	logic [11:0] ms_reg, ms_next;
	logic [11:0] target_reg, target_next;
	logic fire_reg, fire_next;

	wire tick = (cyc_reg == 16'(TICK_CYCLES - 1));
	wire last = tick && (ms_reg == target_reg - 12'h001);

	// Restart wins so a wait always spans a whole stable period
	always_comb begin
		state_next = state_reg;
		cyc_next = cyc_reg;
		ms_next = ms_reg;
		target_next = target_reg;
		fire_next = 1'b0;
		if (restart_i) begin
			target_next = target_ms_i;
			cyc_next = 16'h0000;
			ms_next = 12'h000;
			if (target_ms_i == 12'h000) begin
				fire_next = 1'b1;
				state_next = AOFSC_TM_IDLE;
			end else begin
				state_next = AOFSC_TM_WAIT;
			end
		end else begin
			unique case (state_reg)
				AOFSC_TM_IDLE: begin
				end
				AOFSC_TM_WAIT: begin
					if (last) begin
						fire_next = 1'b1;
						state_next = AOFSC_TM_IDLE;
					end else if (tick) begin
						cyc_next = 16'h0000;
						ms_next = ms_reg + 12'h001;
					end else begin
						cyc_next = cyc_reg + 16'h0001;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= AOFSC_TM_IDLE;
			cyc_reg <= 16'h0000;
			ms_reg <= 12'h000;
			target_reg <= 12'h000;
			fire_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cyc_reg <= cyc_next;
			ms_reg <= ms_next;
			target_reg <= target_next;
			fire_reg <= fire_next;
		end
	end

	assign fire_o = fire_reg;

endmodule : aofsc_ms_timer

// ==== src/aofsc_cfg.sv ====
`timescale 1ns/1ps
module aofsc_cfg #(
	parameter int unsigned TICK_CYCLES = aofsc_pkg::TICK_CYCLES
) (
	input wire logic clk_i, // Clock, 40 MHz
	input wire logic rst_i, // Synchronous reset, high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte select
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic orient_updown_i, // Up/down orientation bit
	input wire logic orient_other_change_i, // Other orientation change, pulse
	output logic orient_irq_o, // Orientation interrupt pulse
	output logic [5:0] orient_theta_o, // Orientation blocking angle
	input wire logic [5:0] tilt_angle_i, // Tilt angle sample
	input wire logic tilt_valid_i, // Tilt sample strobe
	output logic flat_o, // Flat state
	output logic flat_irq_o, // Flat interrupt pulse
	input wire logic [5:0] fifo_level_i, // Sample FIFO entry count
	output logic wm_irq_o, // Watermark interrupt pulse
	output logic st_amp_o, // Self-test high amplitude
	output logic st_sign_o, // Self-test positive sign
	output logic [1:0] st_axis_o, // Self-test axis
	output logic st_settled_o // Self-test settle time elapsed
);
	import aofsc_pkg::*;

	default clocking aofsc_cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Register file
	logic [7:0] orient_reg, orient_next;
	logic [7:0] flat_angle_reg, flat_angle_next;
	logic [7:0] flat_hold_reg, flat_hold_next;
	logic [7:0] wm_reg, wm_next;
	logic [7:0] st_reg, st_next;
	logic ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	logic [7:0] rd_byte;

	// Detector state
	logic ud_prev_reg, ud_seen_reg, orient_irq_reg, orient_irq_next;
	logic flat_reg;
	logic wm_eq_prev_reg, wm_irq_reg, wm_irq_next;
	logic [1:0] st_axis_prev_reg;
	logic st_settled_reg, st_settled_next;
	logic st_fire;

	// Bus decode
	wire bus_req = wb_cyc_i & wb_stb_i;
	wire [5:0] bus_idx = wb_adr_i[ADR_IDX_MSB:ADR_IDX_LSB];
	// Writes land at the edge where the master sees ack
	wire bus_wr = bus_req & wb_we_i & wb_sel_i[0] & ack_reg;
	wire [7:0] wr_byte = wb_dat_i[7:0];
	wire wr_orient = bus_wr & (bus_idx == IDX_ORIENT);
	wire wr_flat_angle = bus_wr & (bus_idx == IDX_FLAT_ANGLE);
	wire wr_flat_hold = bus_wr & (bus_idx == IDX_FLAT_HOLD);
	wire wr_wm = bus_wr & (bus_idx == IDX_WM);
	wire wr_st = bus_wr & (bus_idx == IDX_ST);

	// Reserved bits are never stored, so they read back as zero
	assign orient_next = wr_orient ? (wr_byte & MASK_ORIENT) : orient_reg;
	assign flat_angle_next = wr_flat_angle ? (wr_byte & MASK_FLAT_ANGLE) : flat_angle_reg;
	assign flat_hold_next = wr_flat_hold ? (wr_byte & MASK_FLAT_HOLD) : flat_hold_reg;
	assign wm_next = wr_wm ? (wr_byte & MASK_WM) : wm_reg;
	assign st_next = wr_st ? (wr_byte & MASK_ST) : st_reg;

	// Field views
	wire updown_change_irq_enable = orient_reg[UD_EN_BIT];
	wire [5:0] flat_theta = flat_angle_reg[THETA_MSB:0];
	wire [1:0] hold_sel = flat_hold_reg[HOLD_MSB:HOLD_LSB];
	wire [2:0] flat_hysteresis_value = flat_hold_reg[HY_MSB:0];
	wire [5:0] wm_level = wm_reg[THETA_MSB:0];
	wire [1:0] st_axis = st_reg[ST_AXIS_MSB:0];

	wire [7:0] status_byte = {5'h00, st_settled_reg, ud_prev_reg, flat_reg};

	always_comb begin
		rd_byte = 8'h00;
		case (bus_idx)
			IDX_ORIENT: rd_byte = orient_reg;
			IDX_FLAT_ANGLE: rd_byte = flat_angle_reg;
			IDX_FLAT_HOLD: rd_byte = flat_hold_reg;
			IDX_WM: rd_byte = wm_reg;
			IDX_ST: rd_byte = st_reg;
			IDX_STATUS: rd_byte = status_byte;
			default: rd_byte = 8'h00;
		endcase
	end

	// One wait state; unmapped addresses are acknowledged and read zero
	assign ack_next = bus_req & ~ack_reg;
	assign dat_next = ack_next ? {24'h000000, rd_byte} : dat_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			orient_reg <= RST_ORIENT;
			flat_angle_reg <= RST_FLAT_ANGLE;
			flat_hold_reg <= RST_FLAT_HOLD;
			wm_reg <= RST_WM;
			st_reg <= RST_ST;
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end else begin
			orient_reg <= orient_next;
			flat_angle_reg <= flat_angle_next;
			flat_hold_reg <= flat_hold_next;
			wm_reg <= wm_next;
			st_reg <= st_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	// Orientation: first sample after reset only primes the history
	wire ud_change = ud_seen_reg & (orient_updown_i != ud_prev_reg);
	assign orient_irq_next = (ud_change & updown_change_irq_enable) | orient_other_change_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ud_prev_reg <= 1'b0;
			ud_seen_reg <= 1'b0;
			orient_irq_reg <= 1'b0;
		end else begin
			ud_prev_reg <= orient_updown_i;
			ud_seen_reg <= 1'b1;
			orient_irq_reg <= orient_irq_next;
		end
	end

	// Flat detection with a hysteresis band above the threshold
	wire [7:0] tilt_ext = {2'h0, tilt_angle_i};
	wire [7:0] enter_bound = {2'h0, flat_theta};
	wire [7:0] leave_bound = flat_leave_bound(flat_theta, flat_hysteresis_value);
	wire flat_enter = tilt_ext < enter_bound;
	wire flat_leave = tilt_ext >= leave_bound;
	wire flat_cand = flat_reg ? ~flat_leave : flat_enter;
	wire flat_change = tilt_valid_i & (flat_cand != flat_reg);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flat_reg <= 1'b0;
		end else if (flat_change) begin
			flat_reg <= flat_cand;
		end
	end

	// Any state change restarts the hold wait
	aofsc_ms_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_flat_hold (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(flat_change),
		.target_ms_i(hold_ms(hold_sel)),
		.fire_o(flat_irq_o)
	);

	// Cycles since the last flat change; saturates so it never wraps into a match
	logic [31:0] since_change_reg;
	logic [1:0] hold_at_change_reg;
	wire since_full = &since_change_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			since_change_reg <= 32'h00000000;
			hold_at_change_reg <= 2'h0;
		end else if (flat_change) begin
			since_change_reg <= 32'h00000000;
			hold_at_change_reg <= hold_sel;
		end else if (!since_full) begin
			since_change_reg <= since_change_reg + 32'h00000001;
		end
	end

	// Watermark: pulse once as equality begins, not every cycle it holds
	wire wm_eq = fifo_level_i == wm_level;
	assign wm_irq_next = wm_eq & ~wm_eq_prev_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wm_eq_prev_reg <= 1'b1;
			wm_irq_reg <= 1'b0;
		end else begin
			wm_eq_prev_reg <= wm_eq;
			wm_irq_reg <= wm_irq_next;
		end
	end

	// Self-test settle tracking for the host
	wire st_on = st_axis != ST_AXIS_OFF;
	wire st_restart = st_on & (st_axis != st_axis_prev_reg);
	assign st_settled_next = st_on & (st_fire | (st_settled_reg & ~st_restart));

	aofsc_ms_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_st_settle (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(st_restart),
		.target_ms_i(12'(ST_SETTLE_MS)),
		.fire_o(st_fire)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_axis_prev_reg <= ST_AXIS_OFF;
			st_settled_reg <= 1'b0;
		end else begin
			st_axis_prev_reg <= st_axis;
			st_settled_reg <= st_settled_next;
		end
	end

	// Outputs
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign orient_irq_o = orient_irq_reg;
	assign orient_theta_o = orient_reg[THETA_MSB:0];
	assign flat_o = flat_reg;
	assign wm_irq_o = wm_irq_reg;
	assign st_amp_o = st_reg[ST_AMP_BIT];
	assign st_sign_o = st_reg[ST_SIGN_BIT];
	assign st_axis_o = st_axis;
	assign st_settled_o = st_settled_reg;

	ud_irq_a: assert property (
		ud_change && updown_change_irq_enable |=> orient_irq_o
	) else $error("up/down change did not raise orientation interrupt");

	ud_mask_a: assert property (
		ud_seen_reg && !updown_change_irq_enable && !orient_other_change_i |=> !orient_irq_o
	) else $error("masked up/down change raised orientation interrupt");

	theta_wr_a: assert property (
		wr_orient |=> orient_theta_o == $past(wb_dat_i[5:0])
	) else $error("blocking angle not taken from write");

	flat_enter_a: assert property (
		tilt_valid_i && !flat_o && tilt_ext < {2'h0, flat_theta} |=> flat_o
	) else $error("flat state not entered below threshold");

	hold_zero_a: assert property (
		flat_change && hold_sel == 2'h0 |=> flat_irq_o
	) else $error("zero hold time did not fire flat interrupt");

	hold_wait_a: assert property (
		flat_change && hold_sel != 2'h0 |=> !flat_irq_o [*8]
	) else $error("flat interrupt fired before hold time");

	flat_hyst_a: assert property (
		flat_o && tilt_valid_i && flat_hysteresis_value != 3'h0 &&
		tilt_ext <= {2'h0, flat_theta} + {4'h0, flat_hysteresis_value, 1'b0} |=> flat_o
	) else $error("flat state left inside hysteresis band");

	no_hyst_a: assert property (
		flat_hysteresis_value == 3'h0 && flat_o && tilt_valid_i &&
		tilt_ext >= {2'h0, flat_theta}
		|=> !flat_o
	) else $error("flat state kept at threshold without hysteresis");

	wm_cause_a: assert property (
		wm_irq_o |-> $past(fifo_level_i) == $past(wm_level)
	) else $error("watermark interrupt without level match");

	wm_once_a: assert property (
		wm_eq [*2] |=> !wm_irq_o
	) else $error("watermark interrupt repeated while level held");

	st_amp_a: assert property (
		wr_st |=> st_amp_o == $past(wb_dat_i[ST_AMP_BIT])
	) else $error("self-test amplitude not taken from write");

	st_sign_a: assert property (
		wr_st |=> st_sign_o == $past(wb_dat_i[ST_SIGN_BIT])
	) else $error("self-test sign not taken from write");

	st_axis_a: assert property (
		wr_st |=> st_axis_o == $past(wb_dat_i[1:0])
	) else $error("self-test axis not taken from write");

	ack_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o
	) else $error("acknowledge held longer than one cycle");

	other_irq_a: assert property (
		orient_other_change_i |=> orient_irq_o
	) else $error("other orientation change raised no interrupt");

	theta_keep_a: assert property (
		!wr_orient |=> $stable(orient_theta_o)
	) else $error("blocking angle changed without a write");

	flat_keep_a: assert property (
		!tilt_valid_i |=> flat_o == $past(flat_o)
	) else $error("flat state changed without a tilt sample");

	hold_exact_a: assert property (
		flat_irq_o |-> since_change_reg == 32'(hold_ms(hold_at_change_reg)) * TICK_CYCLES
	) else $error("flat interrupt not at end of hold time");

	flat_leave_a: assert property (
		flat_o && tilt_valid_i &&
		tilt_ext > {2'h0, flat_theta} + {4'h0, flat_hysteresis_value, 1'b0} |=> !flat_o
	) else $error("flat state kept beyond hysteresis band");

	wm_rise_a: assert property (
		$rose(wm_eq) && !$past(rst_i) |=> wm_irq_o
	) else $error("watermark match raised no interrupt");

	axis_keep_a: assert property (
		!wr_st |=> $stable(st_axis_o)
	) else $error("self-test axis changed without a write");

	settle_off_a: assert property (
		!st_on |=> !st_settled_o
	) else $error("settled shown while self-test off");

	ack_answer_a: assert property (
		bus_req && !wb_ack_o |=> wb_ack_o
	) else $error("bus request not acknowledged");

	ud_irq_c: cover property (ud_change && updown_change_irq_enable ##1 orient_irq_o);
	other_irq_c: cover property (orient_other_change_i ##1 orient_irq_o);
	flat_irq_c: cover property (flat_irq_o && hold_sel != 2'h0);
	wm_irq_c: cover property (wm_irq_o);
	st_settle_c: cover property ($rose(st_settled_o));

endmodule : aofsc_cfg

// ==== verif/aofsc_host.sv ====
`timescale 1ns/1ps
module aofsc_host (
	input wire logic clk_i, // Clock
	input wire logic wb_ack_i, // Acknowledge from block
	input wire logic [31:0] wb_dat_i, // Read data from block
	output logic wb_cyc_o, // Cycle
	output logic wb_stb_o, // Strobe
	output logic wb_we_o, // Write enable
	output logic [7:0] wb_adr_o, // Byte address
	output logic [3:0] wb_sel_o, // Byte select
	output logic [31:0] wb_dat_o // Write data
);
	logic [31:0] last_rd;
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0000_0000;
		last_rd = 32'h0000_0000;
	end
	// Request held until ack is seen at an edge; then released
	task automatic xfer(input logic we, input logic [5:0] idx, input logic [7:0] v);
		@(posedge clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= we;
		wb_adr_o <= {idx, 2'h0};
		wb_sel_o <= 4'h1;
		wb_dat_o <= {24'h00_0000, v};
		// Only the bench watchdog ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (wb_ack_i !== 1'b1);
		last_rd = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o <= 1'b0;
		// Address and write-data lines toggle so stale values never look valid
		wb_adr_o <= ~wb_adr_o;
		wb_dat_o <= ~wb_dat_o;
	endtask : xfer
	task automatic wr(input logic [5:0] idx, input logic [7:0] v);
		xfer(1'b1, idx, v);
	endtask : wr
	task automatic rd(input logic [5:0] idx, output logic [31:0] v);
		xfer(1'b0, idx, 8'h00);
		v = last_rd;
	endtask : rd
endmodule : aofsc_host

// ==== verif/aofsc_cfg_bench.sv ====
`timescale 1ns/1ps
module aofsc_cfg_bench;
	import aofsc_pkg::*;
	localparam int unsigned TICKS = 4;
	logic clk_i, rst_i, cyc, stb, we, ack, updown, other, tvalid, flat, flat_irq;
	logic orient_irq, wm_irq, amp, sign, settled;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rv;
	logic [5:0] theta, tilt, level;
	logic [1:0] axis;
	int errors, total_checks;

	aofsc_cfg #(.TICK_CYCLES(TICKS)) u_aofsc_cfg (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .orient_updown_i(updown),
		.orient_other_change_i(other), .orient_irq_o(orient_irq), .orient_theta_o(theta),
		.tilt_angle_i(tilt), .tilt_valid_i(tvalid), .flat_o(flat), .flat_irq_o(flat_irq),
		.fifo_level_i(level), .wm_irq_o(wm_irq), .st_amp_o(amp), .st_sign_o(sign),
		.st_axis_o(axis), .st_settled_o(settled));
	aofsc_host u_aofsc_host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
		.wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp, input string what);
		u_aofsc_host.rd(idx, rv);
		chk(what, {24'h00_0000, exp}, rv);
	endtask : rdchk
	// Sample taken at the second edge; outputs settle by the next falling edge
	task automatic tilt_in(input logic [5:0] a);
		@(posedge clk_i);
		tilt <= a;
		tvalid <= 1'b1;
		@(posedge clk_i);
		tvalid <= 1'b0;
		@(negedge clk_i);
	endtask : tilt_in

	task automatic t_reset;
		chk("theta out", 32'(RST_ORIENT[THETA_MSB:0]), 32'(theta));
		rdchk(IDX_ORIENT, RST_ORIENT, "orient reg");
		rdchk(IDX_FLAT_ANGLE, RST_FLAT_ANGLE, "flat angle reg");
		rdchk(IDX_FLAT_HOLD, RST_FLAT_HOLD, "flat hold reg");
		rdchk(IDX_WM, RST_WM, "wm reg");
		rdchk(IDX_ST, RST_ST, "st reg");
		rdchk(6'h01, 8'h00, "unmapped");
		$display("test reset done");
	endtask : t_reset

	task automatic t_regs;
		logic [7:0] v;
		u_aofsc_host.wr(IDX_ORIENT, 8'hFF);
		rdchk(IDX_ORIENT, MASK_ORIENT, "orient mask");
		chk("theta max", 32'h3F, 32'(theta));
		u_aofsc_host.wr(IDX_FLAT_ANGLE, 8'hFF);
		rdchk(IDX_FLAT_ANGLE, MASK_FLAT_ANGLE, "flat angle mask");
		u_aofsc_host.wr(IDX_FLAT_HOLD, 8'hFF);
		rdchk(IDX_FLAT_HOLD, MASK_FLAT_HOLD, "flat hold mask");
		u_aofsc_host.wr(IDX_WM, 8'hFF);
		rdchk(IDX_WM, MASK_WM, "wm mask");
		for (int a = 0; a < 4; a++) begin
			v = {3'h0, a[0], 1'b0, a[1], a[1:0]};
			u_aofsc_host.wr(IDX_ST, v);
			@(negedge clk_i);
			chk("st amp", 32'(a[0]), 32'(amp));
			chk("st sign", 32'(a[1]), 32'(sign));
			chk("st axis", 32'(a[1:0]), 32'(axis));
		end
		$display("test registers done");
	endtask : t_regs

	task automatic t_orient;
		u_aofsc_host.wr(IDX_ORIENT, 8'h48);
		@(posedge clk_i);
		updown <= ~updown;
		@(posedge clk_i);
		@(negedge clk_i);
		chk("orient irq on", 32'h1, 32'(orient_irq));
		@(negedge clk_i);
		chk("orient irq one cycle", 32'h0, 32'(orient_irq));
		u_aofsc_host.wr(IDX_ORIENT, 8'h08);
		@(posedge clk_i);
		updown <= ~updown;
		repeat (3) begin
			@(negedge clk_i);
			chk("orient irq masked", 32'h0, 32'(orient_irq));
		end
		@(posedge clk_i);
		other <= 1'b1;
		@(posedge clk_i);
		other <= 1'b0;
		@(negedge clk_i);
		chk("other change irq", 32'h1, 32'(orient_irq));
		$display("test orientation done");
	endtask : t_orient

	task automatic t_flat;
		int n;
		int unsigned ms;
		u_aofsc_host.wr(IDX_FLAT_ANGLE, 8'h10);
		u_aofsc_host.wr(IDX_FLAT_HOLD, 8'h02);
		tilt_in(6'h0F);
		chk("flat enter", 32'h1, 32'(flat));
		chk("flat irq hold 0", 32'h1, 32'(flat_irq));
		tilt_in(6'h14);
		chk("flat inside band", 32'h1, 32'(flat));
		tilt_in(6'h15);
		chk("flat leave", 32'h0, 32'(flat));
		u_aofsc_host.wr(IDX_FLAT_HOLD, 8'h00);
		tilt_in(6'h0F);
		tilt_in(6'h10);
		chk("flat leave no band", 32'h0, 32'(flat));
		// Each nonzero hold setting in turn; flat state alternates so every step is a change
		for (int h = 1; h < 4; h++) begin
			u_aofsc_host.wr(IDX_FLAT_HOLD, 8'(h << HOLD_LSB));
			tilt_in(h[0] ? 6'h0F : 6'h10);
			n = 0;
			while (flat_irq !== 1'b1 && n < 9000) begin
				@(negedge clk_i);
				n++;
			end
			ms = (h == 1) ? HOLD1_MS : ((h == 2) ? HOLD2_MS : HOLD3_MS);
			chk("flat hold wait", 32'(ms * TICKS), 32'(n));
		end
		$display("test flat done");
	endtask : t_flat

	task automatic t_wm;
		u_aofsc_host.wr(IDX_WM, 8'h05);
		@(posedge clk_i);
		level <= 6'h05;
		@(negedge clk_i);
		chk("wm early", 32'h0, 32'(wm_irq));
		@(negedge clk_i);
		chk("wm irq", 32'h1, 32'(wm_irq));
		@(negedge clk_i);
		chk("wm no repeat", 32'h0, 32'(wm_irq));
		$display("test watermark done");
	endtask : t_wm

	task automatic t_self_test;
		int n;
		chk("settled before", 32'h1, 32'(settled));
		u_aofsc_host.wr(IDX_ST, 8'h00);
		repeat (2) @(negedge clk_i);
		chk("settled off", 32'h0, 32'(settled));
		u_aofsc_host.wr(IDX_ST, 8'h01);
		@(negedge clk_i);
		chk("st axis x", 32'h1, 32'(axis));
		n = 0;
		while (settled !== 1'b1 && n < 1000) begin
			@(negedge clk_i);
			n++;
		end
		chk("settle wait", 32'(ST_SETTLE_MS * TICKS + 2), 32'(n));
		rdchk(IDX_STATUS, 8'((1 << STAT_SETTLED_BIT) | (1 << STAT_FLAT_BIT)), "status");
		u_aofsc_host.wr(IDX_ST, 8'h00);
		repeat (2) @(negedge clk_i);
		chk("settled cleared", 32'h0, 32'(settled));
		$display("test self-test done");
	endtask : t_self_test

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (40000) @(posedge clk_i);
		errors++;
		$display("watchdog expired");
		tally_and_finish();
	end

	initial begin
		errors = 0;
		total_checks = 0;
		rst_i = 1'b1;
		updown = 1'b0;
		other = 1'b0;
		tvalid = 1'b0;
		tilt = 6'h3F;
		level = 6'h04;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_regs();
		t_orient();
		t_flat();
		t_wm();
		t_self_test();
		tally_and_finish();
	end
endmodule : aofsc_cfg_bench
